// ---- logic/bus_cfg_pkg.sv ----
// Package for the bus control and boot configuration block.
// Assumes an 8-bit processor bus with a 16-bit address, single clock.
package bus_cfg_pkg;
    // ****************************************************************
    // Register map and fields
    // ****************************************************************
    localparam logic [15:0] BUS_CONTROL_ADDR = 16'h001B;
    localparam int EXT_BUS_SELECT_BIT = 0;
    localparam int TEST_MODE_BIT = 3;
    localparam int EXT_ROM_SELECT_BIT = 7;
    localparam logic [7:0] BUS_CONTROL_RESET = 8'h00;
    localparam logic [7:0] BUS_CONTROL_TEST = 8'h89;

    // ****************************************************************
    // Memory windows
    // ****************************************************************
    localparam logic [15:0] ROM_BASE = 16'hF000;
    localparam logic [15:0] ROM_LAST = 16'hFFFF;
    localparam int ROM_BYTES = 4096;
    localparam logic [15:0] RAM_ZP_BASE = 16'h0040;
    localparam logic [15:0] RAM_ZP_LAST = 16'h00FF;
    localparam logic [15:0] RAM_SP_BASE = 16'h0140;
    localparam logic [15:0] RAM_SP_LAST = 16'h01FF;
    localparam int RAM_BYTES = 192;
    localparam logic [7:0] READ_IDLE = 8'h00;

    // Bus request carried into the block.
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic rd;
        logic wr;
    } bus_req_t;

    // Configuration seen by the rest of the chip.
    typedef struct packed {
        logic ext_rom;
        logic test_mode;
        logic ext_bus;
        logic ext_processor;
    } cfg_t;
endpackage

// ---- logic/level_sync.sv ----
// Three-stage synchroniser with agreement filter for one pin level.
// Assumes the pin is asynchronous to clk_i and that clk_i keeps running
// while the chip reset is held, so the level is known at release.
`timescale 1ns/100ps
`default_nettype none
module level_sync (
    // Clock.
    input wire logic clk_i,
    // Pin and filtered level.
    input wire logic pin_i,
    output logic level_o
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    // No reset: the level just before reset release is a strap, so the
    // stages must follow the pin while reset is still held low.
    // Only the second stage reads the first; level moves when 2 and 3 agree.
    always_ff @(posedge clk_i) begin
        s1_reg <= pin_i;
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        if (s2_reg == s3_reg) begin
            level_o <= s3_reg;
        end
    end
endmodule
`default_nettype wire

// ---- logic/bus_control_boot_config.sv ----
// Bus control register, boot strap capture, ROM and RAM decode.
// Assumes a processor bus on clk_i with one-cycle rd and wr strobes,
// and a clk_i that keeps running while rstn_i is held low, so that the
// bus enable strap is already filtered when reset is released.
`timescale 1ns/100ps
`default_nettype none
module bus_control_boot_config #(
    parameter int ROM_DEPTH = bus_cfg_pkg::ROM_BYTES,
    parameter int RAM_DEPTH = bus_cfg_pkg::RAM_BYTES
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rstn_i,
    // Pins.
    input wire logic bus_enable_in_i,
    // Processor bus.
    input wire bus_cfg_pkg::bus_req_t req_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    output logic rom_sel_o,
    output logic ram_sel_o,
    // Configuration.
    output bus_cfg_pkg::cfg_t cfg_o
);
    // ****************************************************************
    // Storage and decode helpers
    // ****************************************************************
    logic [7:0] rom_mem [ROM_DEPTH];
    logic [7:0] ram_mem [RAM_DEPTH];
    logic [7:0] bus_control_reg;
    logic [7:0] bus_control_next;
    logic strap_pending_reg;
    logic be_level;
    logic rd_reg_hit;
    logic rd_ram_hit;
    logic rd_rom_hit;

    // Offset width of the ROM array follows its depth.
    localparam int ROM_AW = $clog2(ROM_DEPTH);

    // Mask contents are constant; zero here, a real part loads its image.
    initial begin
        for (int i = 0; i < ROM_DEPTH; i++) begin
            rom_mem[i] = 8'h00;
        end
    end

    // ****************************************************************
    // Address decode
    // ****************************************************************
    function automatic logic in_rom(input logic [15:0] a);
        in_rom = (a >= bus_cfg_pkg::ROM_BASE) && (a <= bus_cfg_pkg::ROM_LAST);
    endfunction

    function automatic logic in_ram(input logic [15:0] a);
        in_ram = ((a >= bus_cfg_pkg::RAM_ZP_BASE) &&
                  (a <= bus_cfg_pkg::RAM_ZP_LAST)) ||
                 ((a >= bus_cfg_pkg::RAM_SP_BASE) &&
                  (a <= bus_cfg_pkg::RAM_SP_LAST));
    endfunction

    // Both windows show the same array: the stack page is an alias of
    // page zero. Each window is as large as the array, so folding them
    // onto separate halves would leave half of each window unbacked.
    function automatic logic [7:0] ram_index(input logic [15:0] a);
        logic [15:0] off;
        off = 16'h0000;
        if (a[15:8] == bus_cfg_pkg::RAM_SP_BASE[15:8]) begin
            off = a - bus_cfg_pkg::RAM_SP_BASE;
        end else begin
            off = a - bus_cfg_pkg::RAM_ZP_BASE;
        end
        ram_index = off[7:0];
    endfunction

    // Offset inside the ROM array; the window ends at the top of memory.
    function automatic logic [ROM_AW-1:0] rom_offset(input logic [15:0] a);
        logic [15:0] off;
        off = a - bus_cfg_pkg::ROM_BASE;
        rom_offset = off[ROM_AW-1:0];
    endfunction

    // The register sits at one address; writes and reads both decode it.
    function automatic logic is_bus_control(input logic [15:0] a);
        is_bus_control = (a == bus_cfg_pkg::BUS_CONTROL_ADDR);
    endfunction

    // ****************************************************************
    // Bus enable strap
    // ****************************************************************
    // The pin is filtered without reset: its level just before release is
    // the strap, and a synchroniser held in reset would always read low.
    level_sync u_be_sync (
        .clk_i(clk_i),
        .pin_i(bus_enable_in_i),
        .level_o(be_level)
    );

    // Pending is set by reset and taken on the first edge after release.
    // The pin must have settled about four clocks before release to count
    // as high at release; a later rise is read as a test start.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            strap_pending_reg <= 1'b1;
        end else begin
            strap_pending_reg <= 1'b0;
        end
    end

    // Bus control register: strap preset once, software after that.
    always_comb begin
        bus_control_next = bus_control_reg;
        if (strap_pending_reg) begin
            // High already means normal, low means bus enable rises late.
            if (be_level) begin
                bus_control_next = bus_cfg_pkg::BUS_CONTROL_RESET;
            end else begin
                bus_control_next = bus_cfg_pkg::BUS_CONTROL_TEST;
            end
        end else if (req_i.wr && is_bus_control(req_i.addr)) begin
            // The core has no bit-set or bit-clear opcodes, so software
            // changes a field by writing the whole byte back.
            bus_control_next = req_i.wdata;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bus_control_reg <= bus_cfg_pkg::BUS_CONTROL_RESET;
        end else begin
            bus_control_reg <= bus_control_next;
        end
    end

    // ****************************************************************
    // Configuration outputs
    // ****************************************************************
    // Processor choice follows the live pin level, as bus enable doubles
    // as a bus grant in test systems.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cfg_o <= '0;
        end else begin
            cfg_o.ext_rom <=
                bus_control_next[bus_cfg_pkg::EXT_ROM_SELECT_BIT];
            cfg_o.test_mode <=
                bus_control_next[bus_cfg_pkg::TEST_MODE_BIT];
            cfg_o.ext_bus <=
                bus_control_next[bus_cfg_pkg::EXT_BUS_SELECT_BIT];
            cfg_o.ext_processor <= ~be_level;
        end
    end

    // ****************************************************************
    // ROM and RAM access
    // ****************************************************************
    // Read hits, in priority order: register, RAM, then on-chip ROM.
    // The ROM window goes quiet while external ROM is chosen, so an
    // outside memory can answer there without a fight on the bus.
    assign rd_reg_hit = req_i.rd && is_bus_control(req_i.addr);
    assign rd_ram_hit = req_i.rd && !rd_reg_hit &&
                        in_ram(req_i.addr);
    assign rd_rom_hit = req_i.rd && !rd_reg_hit && !rd_ram_hit &&
                        in_rom(req_i.addr) &&
                        !bus_control_reg[bus_cfg_pkg::EXT_ROM_SELECT_BIT];

    // RAM write; static storage, never cleared or refreshed, so the
    // contents hold for as long as the supply does.
    always_ff @(posedge clk_i) begin
        if (req_i.wr && in_ram(req_i.addr)) begin
            ram_mem[ram_index(req_i.addr)] <= req_i.wdata;
        end
    end

    // Read valid marks the cycle after any read, mapped or not.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= req_i.rd;
        end
    end

    // Source selects pulse with read valid for the memory that answered.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rom_sel_o <= 1'b0;
            ram_sel_o <= 1'b0;
        end else begin
            rom_sel_o <= rd_rom_hit;
            ram_sel_o <= rd_ram_hit;
        end
    end

    // Read data one cycle after rd; idle whenever nothing answers, so a
    // stale byte never lingers on the bus. A read changes nothing stored.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o <= bus_cfg_pkg::READ_IDLE;
        end else begin
            rdata_o <= bus_cfg_pkg::READ_IDLE;
            if (rd_reg_hit) begin
                rdata_o <= bus_control_reg;
            end else if (rd_ram_hit) begin
                rdata_o <= ram_mem[ram_index(req_i.addr)];
            end else if (rd_rom_hit) begin
                rdata_o <= rom_mem[rom_offset(req_i.addr)];
            end
        end
    end
endmodule
`default_nettype wire

// ---- verification/bus_cfg_checker.sv ----
// Checker of the bus control block: decode, strap and register effects.
// Assumes a bind to the block and one clock domain.
`timescale 1ns/100ps
`default_nettype none
module bus_cfg_checker (
    // Ports of the block.
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic bus_enable_in_i,
    input wire bus_cfg_pkg::bus_req_t req_i,
    input wire logic [7:0] rdata_o,
    input wire logic rvalid_o,
    input wire logic rom_sel_o,
    input wire logic ram_sel_o,
    input wire bus_cfg_pkg::cfg_t cfg_o
);
    logic rom_rd, ram_rd, reg_hit;
    logic [2:0] wsel;
    // Decode; the ROM window is empty while external ROM is chosen.
    assign rom_rd = req_i.rd && req_i.addr[15:12] == 4'hF && !cfg_o.ext_rom;
    assign ram_rd = req_i.rd && req_i.addr[15:9] == 7'h00 &&
        req_i.addr[7:6] != 2'h0;
    assign reg_hit = req_i.addr == bus_cfg_pkg::BUS_CONTROL_ADDR;
    assign wsel = {req_i.wdata[7], req_i.wdata[3], req_i.wdata[0]};
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // The strap shows one edge after release and is checked two edges later, all three bits alike.
    sequence strap_s;
        ##2 (cfg_o.test_mode != $past(bus_enable_in_i, 2) &&
            cfg_o.ext_rom == cfg_o.test_mode &&
            cfg_o.ext_bus == cfg_o.ext_rom);
    endsequence
    a_valid_pulse: assert property (rvalid_o == $past(req_i.rd))
        else $error("read valid wrong");
    a_rom_decode: assert property (rom_sel_o == $past(rom_rd))
        else $error("ROM select wrong");
    a_ram_decode: assert property (ram_sel_o == $past(ram_rd))
        else $error("RAM select wrong");
    a_unmapped_zero: assert property (rvalid_o && !rom_sel_o &&
        !ram_sel_o && !$past(reg_hit) |-> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_strap_level: assert property (
        $rose(rstn_i) |-> strap_s) else $error("strap preset wrong");
    a_pin_ignored: assert property ($past(rstn_i) &&
        $changed(bus_enable_in_i) && !req_i.wr |=> $stable(cfg_o[3:1]))
        else $error("pin changed the register");
    a_write_config: assert property (req_i.wr && reg_hit |=>
        cfg_o[3:1] == $past(wsel)) else $error("write not applied");
    a_ext_processor: assert property (
        $stable(bus_enable_in_i) [*8] |->
        cfg_o.ext_processor == !bus_enable_in_i) else $error("mode wrong");
endmodule
bind bus_control_boot_config bus_cfg_checker chk (.clk_i(clk_i),
    .rstn_i(rstn_i), .bus_enable_in_i(bus_enable_in_i), .req_i(req_i),
    .rdata_o(rdata_o), .rvalid_o(rvalid_o), .rom_sel_o(rom_sel_o),
    .ram_sel_o(ram_sel_o), .cfg_o(cfg_o));
`default_nettype wire

// ---- verification/ext_master_model.sv ----
// Model of the far-side master that owns the bus enable pin.
// Assumes the bench picks a test or normal start and may drop the pin.
`timescale 1ns/100ps
`default_nettype none
module ext_master_model (
    // Clock, reset, bench controls and pin.
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic test_i,
    input wire logic drop_i,
    output logic bus_enable_o
);
    // A normal start raises the pin before release, a test start after.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bus_enable_o <= !test_i;
        end else begin
            bus_enable_o <= !drop_i;
        end
    end
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// Bench for the bus control block: a table of bus cycles, then straps.
// Assumes the block, its checker bind and the far-side master model.
`timescale 1ns/100ps
`default_nettype none
module tb;
    typedef struct packed {logic wr; logic [15:0] addr; logic [7:0] data;
        logic rom; logic ram;} row_t;
    logic clk_i = 1'b0, rstn_i = 1'b0, test_mode = 1'b0, drop = 1'b0;
    logic bus_enable, rvalid, rom_sel, ram_sel;
    logic [7:0] rdata;
    bus_cfg_pkg::bus_req_t req = '0;
    bus_cfg_pkg::cfg_t cfg;
    int errors = 0;
    int cmp_count = 0;
    // Each write comes before the reads that rely on it; 0140 and 00FF
    // read the stack-page and page-zero aliases of the first two writes.
    row_t rows [20] = '{
        {1'b1, 16'h0040, 8'hA5, 2'b00}, {1'b1, 16'h01FF, 8'h5A, 2'b00},
        {1'b0, 16'h0040, 8'hA5, 2'b01}, {1'b0, 16'h01FF, 8'h5A, 2'b01},
        {1'b0, 16'h0140, 8'hA5, 2'b01}, {1'b0, 16'h00FF, 8'h5A, 2'b01},
        {1'b0, 16'h003F, 8'h00, 2'b00}, {1'b0, 16'h0100, 8'h00, 2'b00},
        {1'b0, 16'h013F, 8'h00, 2'b00}, {1'b0, 16'hF000, 8'h00, 2'b10},
        {1'b0, 16'hFFFF, 8'h00, 2'b10}, {1'b0, 16'hEFFF, 8'h00, 2'b00},
        {1'b0, 16'h001B, 8'h00, 2'b00}, {1'b1, 16'h001B, 8'h80, 2'b00},
        {1'b0, 16'h001B, 8'h80, 2'b00}, {1'b0, 16'hF000, 8'h00, 2'b00},
        {1'b1, 16'h001B, 8'h09, 2'b00}, {1'b0, 16'h001B, 8'h09, 2'b00},
        {1'b0, 16'hFFFF, 8'h00, 2'b10}, {1'b1, 16'h001B, 8'h00, 2'b00}};
    always #2 clk_i = ~clk_i;
    ext_master_model master (.clk_i(clk_i), .rstn_i(rstn_i),
        .test_i(test_mode), .drop_i(drop), .bus_enable_o(bus_enable));
    bus_control_boot_config uut (.clk_i(clk_i), .rstn_i(rstn_i),
        .bus_enable_in_i(bus_enable), .req_i(req), .rdata_o(rdata),
        .rvalid_o(rvalid), .rom_sel_o(rom_sel), .ram_sel_o(ram_sel),
        .cfg_o(cfg));
    task automatic check(input logic [10:0] got, input logic [10:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One bus cycle; a read answer stands for the one cycle after rd.
    task automatic access(input row_t r);
        @(negedge clk_i);
        req <= {r.addr, r.data, !r.wr, r.wr};
        @(negedge clk_i);
        req <= '0;
        if (!r.wr) begin
            check({rvalid, rom_sel, ram_sel, rdata},
                {1'b1, r.rom, r.ram, r.data});
            @(negedge clk_i);
            check({rvalid, rom_sel, ram_sel, rdata}, 11'h000);
        end
    endtask
    // Reset lasts ten cycles; the pin level is set before release.
    task automatic restart(input logic t);
        test_mode = t;
        rstn_i = 1'b0;
        repeat (10) @(negedge clk_i);
        rstn_i = 1'b1;
        repeat (4) @(negedge clk_i);
    endtask
    task automatic stop_test;
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        restart(1'b0);
        check({7'h0, cfg}, 11'h000);
        foreach (rows[i]) access(rows[i]);
        $display("table test done");
        restart(1'b1);
        access({1'b0, 16'h001B, 8'h89, 2'b00});
        check({7'h0, cfg}, 11'h00E);
        access({1'b0, 16'hF000, 8'h00, 2'b00});
        $display("test strap done");
        drop = 1'b1;
        repeat (10) @(negedge clk_i);
        check({7'h0, cfg}, 11'h00F);
        access({1'b0, 16'h001B, 8'h89, 2'b00});
        access({1'b1, 16'h001B, 8'h00, 2'b00});
        check({7'h0, cfg}, 11'h001);
        $display("pin ignored test done");
        stop_test;
    end
endmodule
`default_nettype wire
